// ---- src/srw_defs.svh ----
// Constants for the system reset and watchdog control block.
//
// Notes on behaviour
// RL1 - On reset exit fetch starts at the fixed reset location holding a jump opcode.
// RL2 - During reset peripherals are off and pins are plain inputs without pulls.
// RL3 - Each reset source has its own status bit; the debugger reset has none.
// RL4 - The external pin reset is taken only when reset_pin_enable is set.
// RL5 - After every reset watchdog_enable is set.
// RL6 - With watchdog_enable clear the watchdog never resets the system.
// RL7 - Any write to the reset status address clears the watchdog, contents unchanged.
// RL8 - Watchdog counts 1-kHz ticks; overflow at 32 or 256, long by default.
// RL9 - An enabled watchdog reaching overflow generates a system reset.
// RL10 - The first options register write after reset clears the watchdog counter.
// RL11 - Software writes the options register early to lock the watchdog settings.
// RL12 - In background debug mode the watchdog counter holds.
// RL13 - Stop entry zeroes the watchdog counter; counting restarts from zero after.
// RL14 - No vectored dispatch; module interrupts only wake the CPU, software polls.
// RL15 - A masked source cannot wake, but its module flag still sets.
// RL16 - Pending register bits show per module pending state; writes do nothing.
// RL17 - A pending bit clears once all flags of its module are clear.
// RL18 - Low voltage detector runs when enabled, and in stop only with stop enable.
// RL19 - After power on, hold reset until supply is good, then set power and LV bits.
// RL20 - Other resets set bits of active sources and clear the rest.
// RL21 - A debugger forced reset clears every reset status bit.
// RL22 - The options register takes only its first write after reset.
// RL23 - Watchdog compare uses the latched timeout select; counts only while enabled.
`ifndef SRW_DEFS_SVH
`define SRW_DEFS_SVH

// ***************************************************
// Register offsets.
// ***************************************************
`define SRW_ADDR_STATUS     8'h00
`define SRW_ADDR_OPTIONS    8'h01
`define SRW_ADDR_PENDING    8'h02
`define SRW_ADDR_POWER      8'h03
`define SRW_ADDR_PAGE       8'h04

// ***************************************************
// Field positions.
// ***************************************************
`define SRW_ST_POR          7
`define SRW_ST_PIN          6
`define SRW_ST_WDOG         5
`define SRW_ST_ILLEGAL_OPCODE_RESET         4
`define SRW_ST_ILLEGAL_ADDRESS_RESET         3
`define SRW_ST_LVD          1
`define SRW_OPT_WDEN        7
`define SRW_OPT_WDTO        6
`define SRW_OPT_RESET_PIN_ENABLE       0
`define SRW_PM_LOW_VOLT_STOP_ENABLE        3
`define SRW_PM_LOW_VOLT_DETECT_ENABLE         2

// ***************************************************
// Reset values and fetch start.
// ***************************************************
`define SRW_OPT_RESET       8'hc1
`define SRW_PM_RESET        8'h04
`define SRW_ST_RESET        8'h82
`define SRW_RESET_VECTOR    14'h3ffd
`define SRW_JUMP_OPCODE     8'hbc

// ***************************************************
// Watchdog timing.
// ***************************************************
`define SRW_TICK_MS         1
`define SRW_CLK_KHZ         100000
`define SRW_TICK_CYCLES     (`SRW_TICK_MS * `SRW_CLK_KHZ)
`define SRW_WDOG_SHORT      9'h020
`define SRW_WDOG_LONG       9'h100

`endif

// ---- src/srw_pkg.sv ----
// Types for the system reset and watchdog control block.
package srw_pkg;

    typedef enum logic [1:0] {
        SRW_RUN     = 2'b00,
        SRW_HOLD    = 2'b01,
        SRW_POWERUP = 2'b10
    } srw_state_e;

    typedef struct packed {
        logic       por;
        logic       pin;
        logic       illegal_opcode_reset;
        logic       illegal_address_reset;
        logic       lvd;
        logic       debug_forced_reset_cmd;
    } srw_src_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } srw_bus_s;

endpackage

// ---- src/srw_ctrl.sv ----
// System reset, watchdog, wakeup pending and low voltage enable logic.
`timescale 1ns/1ns
`include "srw_defs.svh"

module srw_ctrl #(
    parameter int          TICK_CYCLES = `SRW_TICK_CYCLES,
    parameter int          NMOD        = 4
) (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Register port.
    input  wire srw_pkg::srw_bus_s    bus,
    output logic [7:0]                rdata,
    // Reset sources.
    input  wire srw_pkg::srw_src_s    src,
    // CPU state.
    input  wire logic                 debug_mode,
    input  wire logic                 stop_mode,
    input  wire logic                 wait_mode,
    input  wire logic                 supply_ok,
    // Module interrupts.
    input  wire logic [NMOD-1:0]      mod_flags,
    input  wire logic [NMOD-1:0]      mod_int_en,
    // Outputs.
    output logic                      cpu_reset,
    output logic [13:0]               fetch_addr,
    output logic                      periph_enable,
    output logic                      pin_drive_en,
    output logic                      pin_pull_en,
    output logic                      cpu_wake,
    output logic                      lvd_active,
    output logic [7:0]                page_select
);
    import srw_pkg::*;

    srw_state_e        state;
    srw_src_s          src_q1;
    srw_src_s          src_s;
    logic [1:0]        stop_q;
    logic [1:0]        supply_q;
    logic [7:0]        status;
    logic [7:0]        options;
    logic              opt_written;
    logic [7:0]        power_ctrl;
    logic [NMOD-1:0]   pending;
    logic [31:0]       tick_cnt;
    logic [8:0]        wdog_cnt;
    logic              wdog_fire;
    logic              stop_in;
    logic              stop_entry;
    logic              supply_s;
    logic              wdog_clear;
    logic              any_reset;
    logic              tick;
    logic [8:0]        wdog_limit;

    // ***************************************************
    // Input synchronisers.
    // ***************************************************
    always_ff @(posedge clk) begin
        src_q1   <= src;
        src_s    <= src_q1;
        stop_q   <= {stop_q[0], stop_mode};
        supply_q <= {supply_q[0], supply_ok};
    end

    assign stop_in  = stop_q[1];
    assign supply_s = supply_q[1];

    logic stop_prev;
    always_ff @(posedge clk) begin
        if (rst) begin
            stop_prev <= 1'b0;
        end else begin
            stop_prev <= stop_in;
        end
    end
    assign stop_entry = stop_in && !stop_prev;

    // ***************************************************
    // Reset request collection.
    // ***************************************************
    // RL4 pin reset gate.
    assign any_reset = src_s.por || src_s.lvd || wdog_fire || src_s.illegal_opcode_reset ||
                       src_s.illegal_address_reset || src_s.debug_forced_reset_cmd ||
                       (src_s.pin && options[`SRW_OPT_RESET_PIN_ENABLE]);

    // RL19 hold until supply good.
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SRW_POWERUP;
        end else begin
            unique case (state)
                SRW_RUN: begin
                    if (any_reset) begin
                        state <= (src_s.por || src_s.lvd) ? SRW_POWERUP : SRW_HOLD;
                    end
                end
                SRW_HOLD: begin
                    if (!any_reset) begin
                        state <= SRW_RUN;
                    end
                end
                SRW_POWERUP: begin
                    if (supply_s && !src_s.por && !src_s.lvd) begin
                        state <= SRW_RUN;
                    end
                end
                default: begin
                    state <= SRW_POWERUP;
                end
            endcase
        end
    end

    // ***************************************************
    // Reset status register.
    // ***************************************************
    // RL3 per source status bits.
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= `SRW_ST_RESET;
        end else if (state == SRW_RUN && any_reset) begin
            status <= 8'h00;
            if (src_s.por) begin
                // RL19 power on bits.
                status[`SRW_ST_POR] <= 1'b1;
                status[`SRW_ST_LVD] <= 1'b1;
            end else if (src_s.lvd) begin
                status[`SRW_ST_LVD] <= 1'b1;
            end else if (!src_s.debug_forced_reset_cmd) begin
                // RL20 active sources recorded.
                status[`SRW_ST_PIN]  <= src_s.pin && options[`SRW_OPT_RESET_PIN_ENABLE];
                status[`SRW_ST_WDOG] <= wdog_fire;
                status[`SRW_ST_ILLEGAL_OPCODE_RESET] <= src_s.illegal_opcode_reset;
                status[`SRW_ST_ILLEGAL_ADDRESS_RESET] <= src_s.illegal_address_reset;
            end
            // RL21 debugger reset clears all.
        end
    end

    // ***************************************************
    // System options, power control and page select registers.
    // ***************************************************
    // RL22 write once options.
    always_ff @(posedge clk) begin
        if (rst || state != SRW_RUN) begin
            // RL5 watchdog enabled after reset.
            options     <= `SRW_OPT_RESET;
            opt_written <= 1'b0;
        end else if (bus.wr && bus.addr == `SRW_ADDR_OPTIONS && !opt_written) begin
            options     <= bus.wdata;
            opt_written <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state != SRW_RUN) begin
            power_ctrl <= `SRW_PM_RESET;
        end else if (bus.wr && bus.addr == `SRW_ADDR_POWER) begin
            power_ctrl <= bus.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state != SRW_RUN) begin
            page_select <= 8'h00;
        end else if (bus.wr && bus.addr == `SRW_ADDR_PAGE) begin
            page_select <= bus.wdata;
        end
    end

    // ***************************************************
    // Watchdog.
    // ***************************************************
    always_ff @(posedge clk) begin
        if (rst || tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

    // RL7 status write clears watchdog.
    // RL10 first options write clears watchdog.
    assign wdog_clear = bus.wr && (bus.addr == `SRW_ADDR_STATUS ||
                        (bus.addr == `SRW_ADDR_OPTIONS && !opt_written));

    // RL8 timeout select.
    // RL23 latched select.
    assign wdog_limit = options[`SRW_OPT_WDTO] ? `SRW_WDOG_LONG : `SRW_WDOG_SHORT;

    always_ff @(posedge clk) begin
        if (rst || state != SRW_RUN || wdog_clear || stop_entry) begin
            // RL13 stop entry zeroes count.
            wdog_cnt <= 9'h000;
        end else if (tick && options[`SRW_OPT_WDEN] && !debug_mode && !stop_in
                     && wdog_cnt < wdog_limit) begin
            // RL12 hold in debug.
            wdog_cnt <= wdog_cnt + 9'h001;
        end
    end

    // RL6 disabled watchdog silent.
    // RL9 overflow resets system.
    assign wdog_fire = options[`SRW_OPT_WDEN] && wdog_cnt >= wdog_limit && state == SRW_RUN;

    // ***************************************************
    // Wakeup, pending indication and low voltage detector enable.
    // ***************************************************
    // RL17 pending tracks module flags.
    always_ff @(posedge clk) begin
        if (rst) begin
            pending  <= '0;
            cpu_wake <= 1'b0;
        end else begin
            pending  <= mod_flags;
            // RL14 wake only, no vector.
            // RL15 masked sources cannot wake.
            cpu_wake <= (stop_in || wait_mode) && |(mod_flags & mod_int_en);
        end
    end

    // RL18 detector enable in stop.
    always_ff @(posedge clk) begin
        if (rst) begin
            lvd_active <= 1'b1;
        end else begin
            lvd_active <= power_ctrl[`SRW_PM_LOW_VOLT_DETECT_ENABLE] &&
                          (!stop_in || power_ctrl[`SRW_PM_LOW_VOLT_STOP_ENABLE]);
        end
    end

    // ***************************************************
    // Reset outputs.
    // ***************************************************
    // RL1 fetch from reset location.
    // RL2 peripherals and pins quiet.
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_reset     <= 1'b1;
            fetch_addr    <= `SRW_RESET_VECTOR;
            periph_enable <= 1'b0;
            pin_drive_en  <= 1'b0;
            pin_pull_en   <= 1'b0;
        end else begin
            cpu_reset     <= state != SRW_RUN || any_reset;
            fetch_addr    <= `SRW_RESET_VECTOR;
            periph_enable <= state == SRW_RUN && !any_reset;
            pin_drive_en  <= 1'b0;
            pin_pull_en   <= 1'b0;
        end
    end

    // ***************************************************
    // Register read port.
    // ***************************************************
    // RL16 pending read only.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `SRW_ADDR_STATUS:  rdata <= status;
                `SRW_ADDR_OPTIONS: rdata <= options;
                `SRW_ADDR_PENDING: rdata <= 8'(pending);
                `SRW_ADDR_POWER:   rdata <= power_ctrl;
                `SRW_ADDR_PAGE:    rdata <= page_select;
                default:           rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ***************************************************
    // Checks.
    // ***************************************************
    AST_WDOG_OFF: assert property (@(posedge clk) disable iff (rst) // RL6
        !options[`SRW_OPT_WDEN] |-> !wdog_fire) else $error("watchdog fired while off");
    AST_WDOG_CLR: assert property (@(posedge clk) disable iff (rst) // RL7
        bus.wr && bus.addr == `SRW_ADDR_STATUS |=> wdog_cnt == 9'h000)
        else $error("watchdog not cleared");
    AST_STAT_KEEP: assert property (@(posedge clk) disable iff (rst) // RL7
        state == SRW_RUN && !any_reset |=> $stable(status)) else $error("status changed");
    AST_ONCE: assert property (@(posedge clk) disable iff (rst) // RL22
        opt_written && state == SRW_RUN |=> $stable(options)) else $error("options rewritten");
    AST_DEBUG: assert property (@(posedge clk) disable iff (rst) // RL12
        debug_mode && !wdog_clear && !stop_entry && state == SRW_RUN ##1 state == SRW_RUN
        |-> wdog_cnt == $past(wdog_cnt)) else $error("count moved in debug");
    AST_STOP: assert property (@(posedge clk) disable iff (rst) // RL13
        stop_entry |=> wdog_cnt == 9'h000) else $error("stop did not zero count");
    AST_FIRE: assert property (@(posedge clk) disable iff (rst) // RL9
        wdog_fire |=> cpu_reset) else $error("no reset on overflow");
    AST_WAKE: assert property (@(posedge clk) disable iff (rst) // RL15
        !(|(mod_flags & mod_int_en)) |=> !cpu_wake) else $error("masked wake");
    AST_LVD: assert property (@(posedge clk) disable iff (rst) // RL18
        stop_in && !power_ctrl[`SRW_PM_LOW_VOLT_STOP_ENABLE] |=> !lvd_active) else $error("lvd on in stop");
    AST_FETCH: assert property (@(posedge clk) disable iff (rst) // RL1
        fetch_addr == `SRW_RESET_VECTOR)
        else $error("fetch address moved");
    AST_QUIET: assert property (@(posedge clk) disable iff (rst) // RL2
        cpu_reset |-> !periph_enable && !pin_drive_en && !pin_pull_en)
        else $error("outputs active in reset");
    AST_SRC_BIT: assert property (@(posedge clk) disable iff (rst) // RL3
        state == SRW_RUN && src_s.illegal_address_reset && !src_s.por && !src_s.lvd &&
        !src_s.debug_forced_reset_cmd |=> status[`SRW_ST_ILLEGAL_ADDRESS_RESET])
        else $error("source bit not recorded");
    AST_PIN_OFF: assert property (@(posedge clk) disable iff (rst) // RL4
        state == SRW_RUN && any_reset && !options[`SRW_OPT_RESET_PIN_ENABLE]
        |=> !status[`SRW_ST_PIN])
        else $error("pin reset taken while disabled");
    AST_WDEN_RST: assert property (@(posedge clk) disable iff (rst) // RL5
        state != SRW_RUN |=> options[`SRW_OPT_WDEN])
        else $error("watchdog off after reset");
    AST_LIMIT: assert property (@(posedge clk) disable iff (rst) // RL8
        wdog_cnt <= wdog_limit)
        else $error("count beyond overflow");
    AST_FIRST_CLR: assert property (@(posedge clk) disable iff (rst) // RL10
        bus.wr && bus.addr == `SRW_ADDR_OPTIONS && !opt_written |=> wdog_cnt == 9'h000)
        else $error("first options write did not clear");
    AST_POR_HOLD: assert property (@(posedge clk) disable iff (rst) // RL19
        state == SRW_POWERUP |-> cpu_reset)
        else $error("cpu released before supply good");
    AST_WDOG_BIT: assert property (@(posedge clk) disable iff (rst) // RL20
        wdog_fire && !src_s.por && !src_s.lvd && !src_s.debug_forced_reset_cmd
        |=> status[`SRW_ST_WDOG])
        else $error("watchdog bit not recorded");
    AST_DBG_RST: assert property (@(posedge clk) disable iff (rst) // RL21
        state == SRW_RUN && src_s.debug_forced_reset_cmd && !src_s.por && !src_s.lvd
        |=> status == 8'h00)
        else $error("debugger reset left status bits");
    AST_NO_COUNT: assert property (@(posedge clk) disable iff (rst) // RL23
        !options[`SRW_OPT_WDEN] |=> wdog_cnt == 9'h000 || wdog_cnt == $past(wdog_cnt))
        else $error("count moved while off");
    AST_WAKE_ON: assert property (@(posedge clk) disable iff (rst) // RL14
        (stop_in || wait_mode) && |(mod_flags & mod_int_en) |=> cpu_wake)
        else $error("enabled source did not wake");
    AST_LVD_ON: assert property (@(posedge clk) disable iff (rst) // RL18
        power_ctrl[`SRW_PM_LOW_VOLT_DETECT_ENABLE] && !stop_in |=> lvd_active)
        else $error("lvd off while enabled");
    AST_PEND_RO: assert property (@(posedge clk) disable iff (rst) // RL16
        bus.wr && bus.addr == `SRW_ADDR_PENDING |=> pending == $past(mod_flags))
        else $error("pending changed by write");
    AST_PEND_CLR: assert property (@(posedge clk) disable iff (rst) // RL17
        mod_flags == '0 |=> pending == '0)
        else $error("pending stuck");

    // ***************************************************
    // Cover points.
    // ***************************************************
    COV_FIRE: cover property (@(posedge clk) wdog_fire);
    COV_ONCE: cover property (@(posedge clk)
        opt_written && bus.wr && bus.addr == `SRW_ADDR_OPTIONS);
    COV_WAKE: cover property (@(posedge clk) cpu_wake);
    COV_POR: cover property (@(posedge clk)
        state == SRW_POWERUP ##1 state == SRW_RUN);
    COV_STOP: cover property (@(posedge clk) stop_entry && wdog_cnt != 9'h000);
endmodule

// ---- tb/srw_cpu_model.sv ----
// Behavioural CPU core that reaches the system control registers.
`timescale 1ns/1ns
module srw_cpu_model (
    // Clock.
    input  wire logic              clk,
    // Register port.
    output srw_pkg::srw_bus_s      bus,
    input  wire logic [7:0]        rdata
);
    import srw_pkg::*;

    initial begin
        bus = '0;
    end

    // ***************************************************
    // Single cycle register accesses.
    // ***************************************************
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        d = rdata;
    endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the system reset and watchdog control block.
`timescale 1ns/1ns
`include "srw_defs.svh"
module testbench;
    import srw_pkg::*;

    logic              clk = 1'b0;
    logic              rst = 1'b1;
    srw_bus_s          bus;
    logic [7:0]        rdata;
    srw_src_s          src = '0;
    logic              debug_mode = 1'b0;
    logic              stop_mode = 1'b0;
    logic              wait_mode = 1'b0;
    logic              supply_ok = 1'b0;
    logic [3:0]        mod_flags = 4'h0;
    logic [3:0]        mod_int_en = 4'h0;
    logic              cpu_reset;
    logic [13:0]       fetch_addr;
    logic              periph_enable;
    logic              pin_drive_en;
    logic              pin_pull_en;
    logic              cpu_wake;
    logic              lvd_active;
    logic [7:0]        page_select;
    int                mismatches = 0;
    int                total_checks = 0;

    always #5 clk = ~clk;

    srw_ctrl #(.TICK_CYCLES(10), .NMOD(4)) i_srw_ctrl (
        .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .src(src),
        .debug_mode(debug_mode), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .supply_ok(supply_ok), .mod_flags(mod_flags), .mod_int_en(mod_int_en),
        .cpu_reset(cpu_reset), .fetch_addr(fetch_addr), .periph_enable(periph_enable),
        .pin_drive_en(pin_drive_en), .pin_pull_en(pin_pull_en), .cpu_wake(cpu_wake),
        .lvd_active(lvd_active), .page_select(page_select)
    );

    srw_cpu_model i_srw_cpu_model (.clk(clk), .bus(bus), .rdata(rdata));

    // ***************************************************
    // Shared checks and sequences.
    // ***************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_srw_cpu_model.read_reg(a, d);
        chk(what, {6'h00, exp}, {6'h00, d});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_srw_cpu_model.write_reg(a, d);
    endtask

    task automatic wait_rst(input logic v, input int max);
        int n;
        n = 0;
        while (cpu_reset !== v && n < max) begin
            @(posedge clk);
            n++;
        end
        chk("cpu_reset", {13'h0000, v}, {13'h0000, cpu_reset});
    endtask

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            seen = seen | cpu_reset;
        end
        chk("no reset", 14'h0000, {13'h0000, seen});
    endtask

    task automatic fire(input int idx, input logic [7:0] exp);
        @(posedge clk);
        src <= srw_src_s'(6'h01 << idx);
        wait_rst(1'b1, 20);
        @(posedge clk);
        src <= '0;
        wait_rst(1'b0, 20);
        rd_chk("status", `SRW_ADDR_STATUS, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ***************************************************
    // Main sequence.
    // ***************************************************
    initial begin
        settle(1);
        chk("periph", 14'h0000, {13'h0000, periph_enable});
        chk("drive", 14'h0000, {12'h000, pin_drive_en, pin_pull_en});
        @(posedge clk);
        rst <= 1'b0;
        settle(1);
        chk("held", 14'h0001, {13'h0000, cpu_reset});
        settle(20);
        chk("held", 14'h0001, {13'h0000, cpu_reset});
        @(posedge clk);
        supply_ok <= 1'b1;
        wait_rst(1'b0, 20);
        chk("periph", 14'h0001, {13'h0000, periph_enable});
        chk("fetch", `SRW_RESET_VECTOR, fetch_addr);
        rd_chk("status", `SRW_ADDR_STATUS, 8'h82);
        rd_chk("options", `SRW_ADDR_OPTIONS, `SRW_OPT_RESET);
        rd_chk("power", `SRW_ADDR_POWER, `SRW_PM_RESET);
        quiet(400);
        wr(`SRW_ADDR_OPTIONS, 8'h80);
        rd_chk("options", `SRW_ADDR_OPTIONS, 8'h80);
        wr(`SRW_ADDR_OPTIONS, 8'hc1);
        rd_chk("options", `SRW_ADDR_OPTIONS, 8'h80);
        repeat (3) begin
            quiet(250);
            wr(`SRW_ADDR_STATUS, 8'hff);
        end
        rd_chk("status", `SRW_ADDR_STATUS, 8'h82);
        wait_rst(1'b1, 400);
        wait_rst(1'b0, 20);
        rd_chk("status", `SRW_ADDR_STATUS, 8'h20);
        rd_chk("options", `SRW_ADDR_OPTIONS, `SRW_OPT_RESET);
        debug_mode <= 1'b1;
        quiet(3000);
        debug_mode <= 1'b0;
        quiet(2000);
        stop_mode <= 1'b1;
        quiet(50);
        stop_mode <= 1'b0;
        quiet(2000);
        wr(`SRW_ADDR_OPTIONS, 8'h41);
        quiet(3000);
        fire(4, 8'h40);
        wr(`SRW_ADDR_OPTIONS, 8'h80);
        src <= srw_src_s'(6'h10);
        quiet(100);
        src <= '0;
        fire(3, 8'h10);
        fire(2, 8'h08);
        fire(0, 8'h00);
        fire(5, 8'h82);
        fire(1, 8'h02);
        mod_flags <= 4'b0101;
        mod_int_en <= 4'b0001;
        wait_mode <= 1'b1;
        settle(4);
        chk("wake", 14'h0001, {13'h0000, cpu_wake});
        rd_chk("pending", `SRW_ADDR_PENDING, 8'h05);
        wr(`SRW_ADDR_PENDING, 8'hff);
        rd_chk("pending", `SRW_ADDR_PENDING, 8'h05);
        mod_int_en <= 4'b0000;
        settle(4);
        chk("wake", 14'h0000, {13'h0000, cpu_wake});
        mod_flags <= 4'b0100;
        rd_chk("pending", `SRW_ADDR_PENDING, 8'h04);
        mod_flags <= 4'b0000;
        wait_mode <= 1'b0;
        rd_chk("pending", `SRW_ADDR_PENDING, 8'h00);
        settle(4);
        chk("lvd", 14'h0001, {13'h0000, lvd_active});
        stop_mode <= 1'b1;
        settle(6);
        chk("lvd", 14'h0000, {13'h0000, lvd_active});
        stop_mode <= 1'b0;
        wr(`SRW_ADDR_POWER, 8'h0c);
        stop_mode <= 1'b1;
        settle(6);
        chk("lvd", 14'h0001, {13'h0000, lvd_active});
        stop_mode <= 1'b0;
        wr(`SRW_ADDR_POWER, 8'h00);
        settle(4);
        chk("lvd", 14'h0000, {13'h0000, lvd_active});
        wr(`SRW_ADDR_PAGE, 8'h08);
        rd_chk("page", `SRW_ADDR_PAGE, 8'h08);
        chk("page_select", 14'h0008, {6'h00, page_select});
        rd_chk("unmapped", 8'h10, 8'h00);
        conclude();
    end

    initial begin
        #300000;
        mismatches++;
        conclude();
    end
endmodule
